// >>> hw/fpx_cfg.svh
// offsets, field positions and reset values of the fp status unit
`ifndef FPX_CFG_SVH
`define FPX_CFG_SVH
// register byte offsets
`define FPX_OFS_TRAPS 8'h00
`define FPX_OFS_BANK 8'h04
`define FPX_OFS_ICODE 8'h08
`define FPX_OFS_FIELD0 8'h10
`define FPX_OFS_FIELD3 8'h1c
// flag and trap enable bit order
`define FPX_B_V 0
`define FPX_B_D 1
`define FPX_B_Z 2
`define FPX_B_O 3
`define FPX_B_U 4
`define FPX_B_I 5
// status field register layout
`define FPX_FLD_CTL_LSB 0
`define FPX_FLD_FLG_LSB 8
`define FPX_CTL_RC_LSB 4
// rounding control codes
`define FPX_RC_NEAR 2'h0
`define FPX_RC_DOWN 2'h1
`define FPX_RC_UP 2'h2
// interruption code bits
`define FPX_IC_V 0
`define FPX_IC_D 1
`define FPX_IC_Z 2
`define FPX_IC_SWA 3
`define FPX_IC_O 11
`define FPX_IC_U 12
`define FPX_IC_I 13
`define FPX_IC_FPA 14
// reset values
`define FPX_RST_CTL 7'h00
`define FPX_RST_TRAPS 6'h3f
// register bank limits
`define FPX_LOW_FIRST 7'h02
`define FPX_HIGH_FIRST 7'h20
`endif

// >>> hw/fpx_pkg.sv
// types shared by the fp status unit
package fpx_pkg;
  // operation issued by the pipeline
  typedef enum logic [2:0] {
    op_chkf = 3'h0,
    op_setc = 3'h1,
    op_clrf = 3'h2,
    op_xma = 3'h3,
    op_arith = 3'h4
  } fpx_op_t;
endpackage

// >>> hw/fpx_unit.sv
// fp status field, exception and integer multiply-add unit
// Function
// RULE1: check-flags branches when alt flag trap-enabled or missing in main
// RULE2: set-controls gives (main controls AND and-mask) OR or-mask
// RULE3: clear-flags zeroes every flag of the chosen field
// RULE4: multiply two 64-bit significands, add zero-extended third, 128 bits
// RULE5: low variant returns bits 63:0, high variant bits 127:64
// RULE6: signed variants treat multiplicands signed, unsigned ones unsigned
// RULE7: sign and exponent ignored, only not-a-thing is looked at
// RULE8: every interruption reported on the causing operation
// RULE9: only highest-priority exception is flagged and shapes the result; code also flags denormal with o, u or i, and inexact with o or u
// RULE10: inexact trap may accompany overflow or underflow trap
// RULE11: disabled-register fault outranks all other fp exceptions
// RULE12: low disable gates regs 2-31, high disable 32-127
// RULE13: fault on assist, enabled invalid, zero divide or denormal
// RULE14: on a fault only the code reports it; flags stay unchanged
// RULE15: assist fault allowed only when no input is not-a-thing
// RULE16: trap on assist, or enabled overflow, underflow or inexact
// RULE17: set flags; when trapping record code and rounded-up bit 14
// RULE18: rounded-up bit set when delivered magnitude exceeds exact one
// RULE19: assist trap sets code bit of a disabled trap
// RULE20: overflow means rounded result exceeds largest finite value
// RULE21: overflow untrapped gives infinity or max finite and inexact
// RULE22: overflow trapped wraps exponent mod 2^17 or 2^8, then traps
// RULE23: underflow untrapped needs tiny and inexact, trapped only tiny
// RULE24: main field plus alternate fields, chosen per operation
// RULE25: invalid over zero divide, overflow and underflow over inexact
`timescale 1ns/100ps
`include "fpx_cfg.svh"

module fpx_unit (
  input wire logic sys_clk,
  input wire logic srst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // operation from the pipeline
  input wire logic op_valid,
  input wire fpx_pkg::fpx_op_t op_kind,
  input wire logic [1:0] op_sf,
  input wire logic [6:0] imm_and,
  input wire logic [6:0] imm_or,
  input wire logic [3:0] reg_use,
  input wire logic [6:0] reg_dst,
  input wire logic [6:0] reg_s1,
  input wire logic [6:0] reg_s2,
  input wire logic [6:0] reg_s3,
  input wire logic nat_in,
  input wire logic xma_signed,
  input wire logic xma_high,
  input wire logic [63:0] sig_a,
  input wire logic [63:0] sig_b,
  input wire logic [63:0] sig_c,
  // raw conditions from the fp datapath
  input wire logic ar_invalid,
  input wire logic ar_denorm,
  input wire logic ar_zdiv,
  input wire logic ar_ovf,
  input wire logic ar_tiny,
  input wire logic ar_inexact,
  input wire logic ar_incr,
  input wire logic ar_sign,
  input wire logic ar_parallel,
  input wire logic [17:0] ar_exp,
  input wire logic ar_swa_fault,
  input wire logic ar_swa_trap,
  input wire logic [2:0] ar_swa_sel,
  // answers to the pipeline
  output logic op_done,
  output logic recover,
  output logic dreg_fault,
  output logic exc_fault,
  output logic exc_trap,
  output logic [15:0] icode,
  output logic [63:0] result,
  output logic result_nat,
  output logic ovf_inf,
  output logic [16:0] wrap_exp
);

  // status register: trap enables and four fields, field 0 is main
  logic [5:0] traps;
  logic [6:0] fctl [4]; // RULE24
  logic [5:0] fflg [4];
  logic bank_lo_dis;
  logic bank_hi_dis;
  logic [1:0] sf_q;

  // apb decode
  wire acc = psel & penable;
  wire [7:0] ofs = paddr[7:0];
  wire hit_traps = ofs == `FPX_OFS_TRAPS;
  wire hit_bank = ofs == `FPX_OFS_BANK;
  wire hit_icode = ofs == `FPX_OFS_ICODE;
  wire hit_field = ofs >= `FPX_OFS_FIELD0 && ofs <= `FPX_OFS_FIELD3 &&
    ofs[1:0] == 2'h0;
  wire [1:0] fidx = ofs[3:2];
  wire mapped = (paddr[31:8] == 24'h0) &
    (hit_traps | hit_bank | hit_icode | hit_field);
  wire wr = acc & pwrite & mapped;
  wire wr_traps = wr & hit_traps;
  wire wr_bank = wr & hit_bank;
  wire wr_field = wr & hit_field;
  wire [31:0] field_rd = {18'h0, fflg[fidx], 1'b0, fctl[fidx]};
  wire [31:0] rd_mux = !mapped ? 32'h0 :
    hit_traps ? {26'h0, traps} :
    hit_bank ? {30'h0, bank_hi_dis, bank_lo_dis} :
    hit_icode ? {16'h0, icode} : field_rd;

  // zero wait states; a write lands at the access edge
  assign pready = acc;
  assign pslverr = acc & ~mapped;

  // read data sampled in setup so it is a flop in the access phase
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      prdata <= 32'h0;
    else if (psel & ~penable)
      prdata <= rd_mux;
  end

  // software-written trap enables and bank disables
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      traps <= `FPX_RST_TRAPS;
      bank_lo_dis <= 1'b0;
      bank_hi_dis <= 1'b0;
    end
    else
    begin
      if (wr_traps)
        traps <= pwdata[5:0];
      if (wr_bank)
      begin
        bank_lo_dis <= pwdata[0];
        bank_hi_dis <= pwdata[1];
      end
    end
  end

  // register bank gating, fr0 and fr1 are never gated
  function automatic logic bank_off(input logic [6:0] r,
    input logic lo, input logic hi);
    bank_off = (lo & r >= `FPX_LOW_FIRST & r < `FPX_HIGH_FIRST) |
      (hi & r >= `FPX_HIGH_FIRST);
  endfunction

  wire uses_fr = op_kind == fpx_pkg::op_xma |
    op_kind == fpx_pkg::op_arith;
  wire dreg_hit = uses_fr & (
    (reg_use[0] & bank_off(reg_dst, bank_lo_dis, bank_hi_dis)) |
    (reg_use[1] & bank_off(reg_s1, bank_lo_dis, bank_hi_dis)) |
    (reg_use[2] & bank_off(reg_s2, bank_lo_dis, bank_hi_dis)) |
    (reg_use[3] & bank_off(reg_s3, bank_lo_dis, bank_hi_dis))); // RULE12
  wire go = op_valid & ~dreg_hit; // RULE11

  // check flags of an alternate field against main flags and traps
  wire [5:0] alt_flg = fflg[op_sf];
  wire chk_branch = |(alt_flg & (traps | ~fflg[0])); // RULE1
  // new controls from immediates
  wire [6:0] setc_ctl = (fctl[0] & imm_and) | imm_or; // RULE2

  // integer multiply-add on significands only
  wire [64:0] xa = {xma_signed & sig_a[63], sig_a}; // RULE6
  wire [64:0] xb = {xma_signed & sig_b[63], sig_b};
  wire signed [129:0] xprod = $signed(xa) * $signed(xb);
  wire [127:0] xsum = xprod[127:0] + {64'h0, sig_c}; // RULE4
  wire [63:0] xsel = xma_high ? xsum[127:64] : xsum[63:0]; // RULE5

  // faults, highest first: invalid, zero divide, denormal, assist
  wire f_inv = ar_invalid & traps[`FPX_B_V];
  wire f_zd = ar_zdiv & traps[`FPX_B_Z];
  wire f_den = ar_denorm & traps[`FPX_B_D];
  wire f_swa = ar_swa_fault & ~nat_in; // RULE15
  wire f_any = f_inv | f_zd | f_den | f_swa; // RULE13
  wire [15:0] f_code =
    f_inv ? 16'h0001 << `FPX_IC_V :
    f_zd ? 16'h0001 << `FPX_IC_Z :
    f_den ? 16'h0001 << `FPX_IC_D : 16'h0001 << `FPX_IC_SWA; // RULE25

  // flag precedence when no fault is taken
  wire e_v = ar_invalid;
  wire e_z = ~e_v & ar_zdiv; // RULE9
  wire e_d = ~e_v & ~e_z & ar_denorm;
  wire e_arith = ~e_v & ~e_z;
  wire e_o = e_arith & ar_ovf; // RULE20
  wire e_u = e_arith & ~ar_ovf & (traps[`FPX_B_U] ? ar_tiny :
    ar_tiny & ar_inexact); // RULE23
  wire e_i = e_arith & (ar_inexact | (ar_ovf & ~traps[`FPX_B_O])); // RULE21
  wire [5:0] ev_flags;
  assign ev_flags[`FPX_B_V] = e_v;
  assign ev_flags[`FPX_B_D] = e_d;
  assign ev_flags[`FPX_B_Z] = e_z;
  assign ev_flags[`FPX_B_O] = e_o;
  assign ev_flags[`FPX_B_U] = e_u;
  assign ev_flags[`FPX_B_I] = e_i;

  // traps; inexact may ride along with overflow or underflow
  wire t_o = e_o & traps[`FPX_B_O];
  wire t_u = e_u & traps[`FPX_B_U];
  wire t_i = e_i & traps[`FPX_B_I]; // RULE10
  wire t_any = t_o | t_u | t_i | ar_swa_trap; // RULE16
  // untrapped overflow picks infinity or max finite by rounding mode
  wire [1:0] rc = fctl[op_sf][`FPX_CTL_RC_LSB +: 2];
  wire use_inf = rc == `FPX_RC_NEAR | (rc == `FPX_RC_DOWN & ar_sign) |
    (rc == `FPX_RC_UP & ~ar_sign); // RULE21
  // only a larger substitute or an increment makes it bigger
  wire fpa = (e_o & ~traps[`FPX_B_O]) ? use_inf : ar_incr; // RULE18
  wire [15:0] t_code;
  assign t_code[10:0] = 11'h0;
  assign t_code[`FPX_IC_O] = t_o | (ar_swa_trap & ar_swa_sel[0]); // RULE19
  assign t_code[`FPX_IC_U] = t_u | (ar_swa_trap & ar_swa_sel[1]);
  assign t_code[`FPX_IC_I] = t_i | (ar_swa_trap & ar_swa_sel[2]);
  assign t_code[`FPX_IC_FPA] = fpa; // RULE17
  assign t_code[15] = 1'b0;
  // trapped overflow wraps the biased exponent
  wire [16:0] wexp = ar_parallel ? {9'h0, ar_exp[7:0]} :
    ar_exp[16:0]; // RULE22

  wire is_ar = go & op_kind == fpx_pkg::op_arith;
  wire ar_flags = is_ar & ~f_any; // RULE14

  // status fields; op effects win over a same-cycle write, datapath flags are ORed into it
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      for (int k = 0; k < 4; k++)
      begin
        fctl[k] <= `FPX_RST_CTL;
        fflg[k] <= 6'h0;
      end
    end
    else
    begin
      if (wr_field)
      begin
        fctl[fidx] <= pwdata[`FPX_FLD_CTL_LSB +: 7];
        fflg[fidx] <= pwdata[`FPX_FLD_FLG_LSB +: 6];
      end
      if (go & op_kind == fpx_pkg::op_setc)
        fctl[op_sf] <= setc_ctl; // RULE2
      if (go & op_kind == fpx_pkg::op_clrf)
        fflg[op_sf] <= 6'h0; // RULE3
      else if (ar_flags)
        fflg[op_sf] <= (wr_field & fidx == op_sf ?
          pwdata[`FPX_FLD_FLG_LSB +: 6] : fflg[op_sf]) |
          ev_flags; // RULE17
    end
  end

  // answers appear the cycle after the op, on the same op
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      op_done <= 1'b0;
      recover <= 1'b0;
      dreg_fault <= 1'b0;
      exc_fault <= 1'b0;
      exc_trap <= 1'b0;
      sf_q <= 2'h0;
    end
    else
    begin
      op_done <= op_valid; // RULE8
      recover <= go & op_kind == fpx_pkg::op_chkf & chk_branch; // RULE1
      dreg_fault <= op_valid & dreg_hit; // RULE11
      exc_fault <= is_ar & f_any; // RULE13
      exc_trap <= ar_flags & t_any; // RULE16
      sf_q <= op_sf;
    end
  end

  // interruption code and results, kept until the next report
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      icode <= 16'h0;
      result <= 64'h0;
      result_nat <= 1'b0;
      ovf_inf <= 1'b0;
      wrap_exp <= 17'h0;
    end
    else
    begin
      if (is_ar & f_any)
        icode <= f_code; // RULE14
      else if (ar_flags & t_any)
        icode <= t_code; // RULE17
      if (go & op_kind == fpx_pkg::op_xma)
      begin
        result <= xsel; // RULE7
        result_nat <= nat_in;
      end
      if (ar_flags & e_o)
      begin
        ovf_inf <= use_inf & ~traps[`FPX_B_O];
        wrap_exp <= wexp;
      end
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  a_chk_branch: assert property ( // RULE1
    op_valid & op_kind == fpx_pkg::op_chkf |=>
      recover == $past(chk_branch))
    else $error("check flags branch wrong");

  a_setc_ctl: assert property ( // RULE2
    op_valid & op_kind == fpx_pkg::op_setc |=>
      fctl[sf_q] == $past(setc_ctl))
    else $error("set controls wrong");

  a_clrf_zero: assert property ( // RULE3
    op_valid & op_kind == fpx_pkg::op_clrf |=> fflg[sf_q] == 6'h0)
    else $error("clear flags left a flag");

  a_xma_res: assert property ( // RULE5
    go & op_kind == fpx_pkg::op_xma & ~xma_high |=>
      result == $past(xsum[63:0]))
    else $error("xma low result wrong");

  a_dreg_first: assert property ( // RULE11
    op_valid & dreg_hit |=> dreg_fault & ~exc_fault & ~exc_trap)
    else $error("disabled register fault not first");

  a_fault_flags: assert property ( // RULE14
    is_ar & f_any & ~wr_field |=>
      exc_fault & fflg[sf_q] == $past(alt_flg))
    else $error("fault changed flags");

  a_ovf_inexact: assert property ( // RULE21
    ar_flags & ar_ovf & ~ar_invalid & ~ar_zdiv & ~traps[`FPX_B_O]
      |=> fflg[sf_q][`FPX_B_I])
    else $error("untrapped overflow missed inexact");

  a_ovf_trap: assert property ( // RULE17
    ar_flags & e_o & traps[`FPX_B_O] |=>
      exc_trap & icode[`FPX_IC_O] & fflg[sf_q][`FPX_B_O])
    else $error("overflow trap not reported");

  a_par_wrap: assert property ( // RULE22
    ar_flags & e_o & ar_parallel |=> wrap_exp[16:8] == 9'h0)
    else $error("parallel exponent not wrapped");

  a_swa_nat: assert property ( // RULE15
    is_ar & nat_in & ~f_inv & ~f_zd & ~f_den |=> ~exc_fault)
    else $error("assist fault with not-a-thing input");

  a_swa_trap: assert property ( // RULE16
    ar_flags & ar_swa_trap |=> exc_trap)
    else $error("assist trap not raised");

  a_dreg_quiet: assert property ( // RULE12
    op_valid & dreg_hit & ~wr_field |=>
      fflg[sf_q] == $past(alt_flg))
    else $error("disabled register op changed flags");

  a_unf_quiet: assert property ( // RULE23
    ar_flags & ar_tiny & ~ar_inexact & ~traps[`FPX_B_U] & ~wr_field |=>
      fflg[sf_q][`FPX_B_U] == $past(alt_flg[`FPX_B_U]))
    else $error("untrapped exact underflow flagged");

endmodule

// >>> verif/fpx_pipe_model.sv
// issue stage of the pipeline that feeds operations to the status unit
`timescale 1ns/100ps
module fpx_pipe_model (
  input wire logic sys_clk,
  input wire logic op_done,
  output logic op_valid,
  output fpx_pkg::fpx_op_t op_kind,
  output logic [1:0] op_sf
);
  int late;
  // quiet until the bench asks for an operation
  initial
  begin
    op_valid = 1'b0;
    op_kind = fpx_pkg::op_chkf;
    op_sf = 2'h0;
    late = 0;
  end
  // idle cycles model a stalled pipeline; answer is due one edge later
  task automatic issue(input fpx_pkg::fpx_op_t k, input logic [1:0] s,
    input int idle);
    repeat (idle) @(posedge sys_clk);
    @(posedge sys_clk);
    op_valid <= 1'b1;
    op_kind <= k;
    op_sf <= s;
    @(posedge sys_clk);
    op_valid <= 1'b0;
    #1;
    if (op_done !== 1'b1)
      late++;
  endtask
endmodule

// >>> verif/fpx_unit_tb.sv
// self-checking bench for the fp status and exception unit
`timescale 1ns/100ps
`include "fpx_cfg.svh"
module fpx_unit_tb;
  logic sys_clk = 1'b0, srst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd, e;
  logic pready, pslverr, op_valid, op_done, recover, dreg_fault, err;
  logic exc_fault, exc_trap, result_nat, ovf_inf;
  fpx_pkg::fpx_op_t op_kind;
  logic [1:0] op_sf;
  logic [6:0] imm_and = 7'h0, imm_or = 7'h0;
  logic [6:0] reg_dst = 7'h0, reg_s1 = 7'h0, reg_s2 = 7'h0, reg_s3 = 7'h0;
  logic [3:0] reg_use = 4'h0;
  logic nat_in = 1'b0, xma_signed = 1'b0, xma_high = 1'b0;
  logic [63:0] sig_a = 64'h0, sig_b = 64'h0, sig_c = 64'h0, result;
  logic ar_invalid = 1'b0, ar_denorm = 1'b0, ar_zdiv = 1'b0, ar_ovf = 1'b0;
  logic ar_tiny = 1'b0, ar_inexact = 1'b0, ar_incr = 1'b0, ar_sign = 1'b0;
  logic ar_parallel = 1'b0, ar_swa_fault = 1'b0, ar_swa_trap = 1'b0;
  logic [2:0] ar_swa_sel = 3'h0;
  logic [17:0] ar_exp = 18'h0;
  logic [15:0] icode;
  logic [16:0] wrap_exp;
  logic [127:0] full;
  logic [6:0] rt [4] = '{7'h02, 7'h01, 7'h1f, 7'h20};
  // fault, trap, enables, conditions, expected code
  logic [31:0] tab [7] = '{{2'h2, 6'h05, 8'h05, 16'h0001},
    {2'h2, 6'h02, 8'h02, 16'h0002}, {2'h2, 6'h04, 8'h04, 16'h0004},
    {2'h2, 6'h00, 8'h40, 16'h0008}, {2'h1, 6'h10, 8'h20, 16'h1000},
    {2'h1, 6'h00, 8'h80, 16'h2000}, {2'h0, 6'h00, 8'h40, 16'h2000}};
  int num_errors = 0, checked = 0, i;

  always #12.5 sys_clk = ~sys_clk;

  fpx_unit dut (.sys_clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .op_valid, .op_kind, .op_sf, .imm_and,
    .imm_or, .reg_use, .reg_dst, .reg_s1, .reg_s2, .reg_s3, .nat_in,
    .xma_signed, .xma_high, .sig_a, .sig_b, .sig_c, .ar_invalid, .ar_denorm,
    .ar_zdiv, .ar_ovf, .ar_tiny, .ar_inexact, .ar_incr, .ar_sign,
    .ar_parallel, .ar_exp, .ar_swa_fault, .ar_swa_trap, .ar_swa_sel,
    .op_done, .recover, .dreg_fault, .exc_fault, .exc_trap, .icode, .result,
    .result_nat, .ovf_inf, .wrap_exp);
  fpx_pipe_model pipe (.sys_clk, .op_done, .op_valid, .op_kind, .op_sf);

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [63:0] seen, exp);
    checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one apb transfer; held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [31:0] a, d);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      num_errors++;
      close_out();
    end
  endtask

  task automatic rdchk(input string what, input logic [31:0] a, exp);
    apb(1'b0, a, 32'h0);
    chk(what, rd, exp);
  endtask

  // main sequence; each step leaves the unit in a known state
  initial
  begin
    repeat (6) @(posedge sys_clk);
    srst <= 1'b0;
    rdchk("traps", `FPX_OFS_TRAPS, 32'h3f);
    rdchk("bank", `FPX_OFS_BANK, 32'h0);
    rdchk("field3", `FPX_OFS_FIELD3, 32'h0);
    apb(1'b1, `FPX_OFS_ICODE, 32'hffff);
    rdchk("icode", `FPX_OFS_ICODE, 32'h0);
    apb(1'b0, 32'h40, 32'h0);
    chk("slverr", err, 1'b1);
    $display("test reset done");
    apb(1'b1, `FPX_OFS_FIELD0, 32'h55);
    imm_and <= 7'h0f;
    imm_or <= 7'h20;
    pipe.issue(fpx_pkg::op_setc, 2'h1, 0);
    rdchk("setc", 32'h14, 32'h25);
    apb(1'b1, 32'h18, 32'h3f2a);
    pipe.issue(fpx_pkg::op_clrf, 2'h2, 2);
    rdchk("clrf", 32'h18, 32'h2a);
    apb(1'b1, 32'h14, 32'h0100);
    for (i = 0; i < 3; i++)
    begin
      apb(1'b1, `FPX_OFS_TRAPS, i == 1);
      apb(1'b1, `FPX_OFS_FIELD0, (i == 2) ? 32'h0 : 32'h3f00);
      pipe.issue(fpx_pkg::op_chkf, 2'h1, 0);
      chk("recover", recover, i != 0);
    end
    $display("test fields done");
    apb(1'b1, `FPX_OFS_TRAPS, 32'h0);
    sig_a <= 64'hffff_ffff_ffff_ffff;
    sig_b <= 64'h8000_0000_0000_0003;
    sig_c <= 64'hffff_ffff_ffff_fff0;
    for (i = 0; i < 4; i++)
    begin
      xma_signed <= i[0];
      xma_high <= i[1];
      nat_in <= (i == 3);
      pipe.issue(fpx_pkg::op_xma, 2'h0, 0);
      full = {64'h0, sig_a} * {64'h0, sig_b} + {64'h0, sig_c};
      if (i[0])
        full = {{64{sig_a[63]}}, sig_a} * {{64{sig_b[63]}}, sig_b} + sig_c;
      chk("xma", result, i[1] ? full[127:64] : full[63:0]);
      chk("nat", result_nat, i == 3);
    end
    nat_in <= 1'b0;
    $display("test xma done");
    // invalid enabled, so a missing bank check would show as a fault
    apb(1'b1, `FPX_OFS_TRAPS, 32'h01);
    ar_invalid <= 1'b1;
    reg_use <= 4'hf;
    for (i = 0; i < 4; i++)
    begin
      apb(1'b1, `FPX_OFS_BANK, (i < 2) ? 32'h1 : 32'h2);
      {reg_dst, reg_s1, reg_s2, reg_s3} <= {4{rt[i]}};
      pipe.issue(fpx_pkg::op_arith, 2'h0, 0);
      chk("dreg", dreg_fault, i == 0 || i == 3);
      chk("fault", exc_fault, i == 1 || i == 2);
    end
    apb(1'b1, `FPX_OFS_BANK, 32'h0);
    $display("test bank done");
    apb(1'b1, `FPX_OFS_FIELD0, 32'h0);
    ar_swa_sel <= 3'h4;
    for (i = 0; i < 7; i++)
    begin
      e = tab[i];
      apb(1'b1, `FPX_OFS_TRAPS, e[29:24]);
      {ar_swa_trap, ar_swa_fault, ar_tiny, ar_inexact, ar_ovf, ar_zdiv,
        ar_denorm, ar_invalid} <= e[23:16];
      nat_in <= (i == 6);
      pipe.issue(fpx_pkg::op_arith, 2'h0, 0);
      chk("fault", exc_fault, e[31]);
      chk("trap", exc_trap, e[30]);
      chk("icode", icode, e[15:0]);
      if (e[31])
        rdchk("flags", `FPX_OFS_FIELD0, 32'h0);
    end
    {ar_swa_trap, ar_swa_fault, ar_tiny, ar_invalid} <= 4'h0;
    nat_in <= 1'b0;
    // untrapped underflow needs inexact too; assist code bits o and u
    apb(1'b1, `FPX_OFS_TRAPS, 32'h0);
    for (i = 0; i < 2; i++)
    begin
      apb(1'b1, `FPX_OFS_FIELD0, 32'h0);
      {ar_tiny, ar_inexact} <= {1'b1, i[0]};
      pipe.issue(fpx_pkg::op_arith, 2'h0, 0);
      chk("unf trap", exc_trap, 1'b0);
      rdchk("unf flags", `FPX_OFS_FIELD0, i[0] ? 32'h3000 : 32'h0);
    end
    {ar_tiny, ar_inexact, ar_swa_trap, ar_swa_sel} <= 6'h0b;
    pipe.issue(fpx_pkg::op_arith, 2'h0, 0);
    chk("swa trap", exc_trap, 1'b1);
    chk("swa code", icode, 16'h1800);
    ar_swa_trap <= 1'b0;
    $display("test events done");
    apb(1'b1, `FPX_OFS_TRAPS, 32'h28);
    {ar_ovf, ar_inexact, ar_incr} <= 3'h7;
    for (i = 0; i < 2; i++)
    begin
      apb(1'b1, `FPX_OFS_FIELD0, 32'h0);
      ar_parallel <= i[0];
      ar_exp <= i[0] ? 18'h0_0105 : 18'h2_0005;
      pipe.issue(fpx_pkg::op_arith, 2'h0, 0);
      chk("trap", exc_trap, 1'b1);
      chk("icode", icode, 16'h6800);
      chk("wrap", wrap_exp, 17'h5);
      rdchk("flags", `FPX_OFS_FIELD0, 32'h2800);
    end
    // untrapped: inexact must be signalled even without the raw condition
    apb(1'b1, `FPX_OFS_TRAPS, 32'h0);
    {ar_inexact, ar_incr, ar_parallel} <= 3'h0;
    for (i = 0; i < 8; i++)
    begin
      apb(1'b1, `FPX_OFS_FIELD0, {i[2:1], 4'h0});
      ar_sign <= i[0];
      pipe.issue(fpx_pkg::op_arith, 2'h0, 0);
      chk("inf", ovf_inf, i < 2 || i == 3 || i == 4);
      chk("trap", exc_trap, 1'b0);
      rdchk("flags", `FPX_OFS_FIELD0, {i[2:1], 4'h0} | 32'h2800);
    end
    chk("late", pipe.late, 64'h0);
    $display("test overflow done");
    close_out();
  end
endmodule
